// >>> src/qpv_decoder.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Channels and index become a position count
// - Velocity is pulses counted per period
// - Velocity runs only with position enabled
// - Phase mode or step/direction mode selectable
// - Phase mode: leading channel gives direction
// - Step mode: one clock, one direction input
// - Phase mode counts channel A or both
// - Swap exchanges channels before all processing
// - Index reset option gives absolute position
// - Timer divides time into equal periods
// - Running and previous period counts readable
// - Events: index, timer, direction, phase error
// - Each event masked before interrupt request
// - Phase mode: both channels changing together flags error
// - Reverse index loads maximum position value
// - Last direction held after motion stops
// - Software clear deasserts selected events
module qpv_decoder
  import qpv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  output logic irq
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  qpv_pins_s pins; // Filtered pin levels
  logic [2:0] pins_raw; // Filtered vector

  qpv_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({enc_index, enc_b, enc_a}),
    .sync_out(pins_raw)
  );
  assign pins = pins_raw;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [QPV_CTRL_W-1:0] ctrl_q; // Mode and enables
  logic [31:0] maxpos_q; // Maximum position value
  logic [31:0] period_q; // Velocity period length in cycles, minus one
  logic [31:0] pos_q; // Position count
  logic [31:0] vel_run_q; // Running pulse total
  logic [31:0] vel_last_q; // Previous period count
  logic [31:0] vtimer_q; // Velocity period timer
  logic dir_q; // Last direction, 1 = reverse
  logic err_q; // Sticky error indicator
  logic [QPV_EV_W-1:0] ev_q; // Sticky event status
  logic [QPV_EV_W-1:0] mask_q; // Event mask, 1 = enabled
  logic a_q; // Previous channel A
  logic b_q; // Previous channel B
  logic idx_q; // Previous index level

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_en; // Write at access phase
  logic known; // Mapped address
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  always_comb begin
    case (paddr)
      QPV_OFF_CTRL, QPV_OFF_MAXPOS, QPV_OFF_POS, QPV_OFF_PERIOD, QPV_OFF_VELRUN,
      QPV_OFF_VELLAST, QPV_OFF_STAT, QPV_OFF_INTSTAT, QPV_OFF_INTMASK: begin
        known = 1'b1;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end
  assign pslverr = psel && penable && !known;

  // ----------------------------------------------------------------
  // Edge decode
  // ----------------------------------------------------------------
  logic ca; // Channel A after swap
  logic cb; // Channel B after swap
  logic ea; // Edge on A
  logic eb; // Edge on B
  logic en; // Position enabled
  logic step; // Counted edge this cycle
  logic rev; // Direction of counted edge
  logic phase_err; // Both channels moved together
  logic idx_hit; // Index rising edge
  logic expire; // Timer expiry

  assign ca = ctrl_q[QPV_CTRL_SWAP] ? pins.chb : pins.cha;
  assign cb = ctrl_q[QPV_CTRL_SWAP] ? pins.cha : pins.chb;
  assign ea = ca ^ a_q;
  assign eb = cb ^ b_q;
  assign en = ctrl_q[QPV_CTRL_ENABLE];
  assign idx_hit = en && pins.idx && !idx_q;

  // Step and direction selection per mode
  always_comb begin
    step = 1'b0;
    rev = dir_q;
    phase_err = 1'b0;
    if (en) begin
      if (ctrl_q[QPV_CTRL_STEPDIR]) begin
        step = ca && !a_q;
        rev = cb;
      end else if (ea && eb) begin
        phase_err = 1'b1;
      end else if (ea) begin
        step = 1'b1;
        rev = (ca == cb);
      end else if (eb) begin
        step = ctrl_q[QPV_CTRL_BOTH];
        rev = (ca != cb);
      end
    end
  end

  // Input history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      idx_q <= 1'b0;
    end else begin
      a_q <= ca;
      b_q <= cb;
      idx_q <= pins.idx;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= QPV_CTRL_RST;
      maxpos_q <= QPV_MAXPOS_RST;
      period_q <= QPV_PERIOD_RST;
      mask_q <= QPV_EV_RST;
    end else if (wr_en) begin
      case (paddr)
        QPV_OFF_CTRL: begin
          ctrl_q <= pwdata[QPV_CTRL_W-1:0];
        end
        QPV_OFF_MAXPOS: begin
          maxpos_q <= pwdata;
        end
        QPV_OFF_PERIOD: begin
          period_q <= pwdata;
        end
        QPV_OFF_INTMASK: begin
          mask_q <= pwdata[QPV_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Position counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= 32'h0000_0000;
    end else if (wr_en && paddr == QPV_OFF_POS) begin
      pos_q <= pwdata;
    end else if (idx_hit && ctrl_q[QPV_CTRL_IDXRST]) begin
      pos_q <= rev ? maxpos_q : 32'h0000_0000;
    end else if (step) begin
      if (rev) begin
        pos_q <= (pos_q == 32'h0000_0000) ? maxpos_q : pos_q - 32'h0000_0001;
      end else begin
        pos_q <= (pos_q == maxpos_q) ? 32'h0000_0000 : pos_q + 32'h0000_0001;
      end
    end
  end

  // Direction memory, kept while motion stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= 1'b0;
    end else if (step) begin
      dir_q <= rev;
    end
  end

  // ----------------------------------------------------------------
  // Velocity unit
  // ----------------------------------------------------------------
  logic vel_on; // Velocity running
  assign vel_on = en && ctrl_q[QPV_CTRL_VEL_EN];
  assign expire = vel_on && (vtimer_q == 32'h0000_0000);

  // Period timer counts down to zero then reloads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vtimer_q <= QPV_PERIOD_RST;
    end else if (!vel_on || expire) begin
      vtimer_q <= period_q;
    end else begin
      vtimer_q <= vtimer_q - 32'h0000_0001;
    end
  end

  // Pulse accumulation and period latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vel_run_q <= 32'h0000_0000;
      vel_last_q <= 32'h0000_0000;
    end else if (expire) begin
      vel_last_q <= vel_run_q + {31'h0000_0000, step};
      vel_run_q <= 32'h0000_0000;
    end else if (vel_on && step) begin
      vel_run_q <= vel_run_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  logic [QPV_EV_W-1:0] ev_set; // Event pulses
  logic [QPV_EV_W-1:0] ev_clr; // Write-one-to-clear
  assign ev_set[QPV_EV_INDEX] = idx_hit;
  assign ev_set[QPV_EV_TIMER] = expire;
  assign ev_set[QPV_EV_DIR] = step && (rev != dir_q);
  assign ev_set[QPV_EV_ERROR] = phase_err;
  assign ev_clr = (wr_en && paddr == QPV_OFF_INTSTAT) ? pwdata[QPV_EV_W-1:0] : QPV_EV_RST;

  // Sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_q <= QPV_EV_RST;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  // Error indicator, cleared with the error event bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (phase_err) begin
      err_q <= 1'b1;
    end else if (ev_clr[QPV_EV_ERROR]) begin
      err_q <= 1'b0;
    end
  end

  assign irq = |(ev_q & mask_q);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (paddr)
      QPV_OFF_CTRL: prdata = {26'h000_0000, ctrl_q};
      QPV_OFF_MAXPOS: prdata = maxpos_q;
      QPV_OFF_POS: prdata = pos_q;
      QPV_OFF_PERIOD: prdata = period_q;
      QPV_OFF_VELRUN: prdata = vel_run_q;
      QPV_OFF_VELLAST: prdata = vel_last_q;
      QPV_OFF_STAT: prdata = {30'h0000_0000, err_q, dir_q};
      QPV_OFF_INTSTAT: prdata = {28'h000_0000, ev_q};
      QPV_OFF_INTMASK: prdata = {28'h000_0000, mask_q};
      default: prdata = 32'h0000_0000;
    endcase
  end

endmodule // qpv_decoder
`default_nettype wire

// >>> inc/qpv_pkg.sv
package qpv_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] QPV_OFF_CTRL = 8'h00;
  localparam logic [7:0] QPV_OFF_MAXPOS = 8'h04;
  localparam logic [7:0] QPV_OFF_POS = 8'h08;
  localparam logic [7:0] QPV_OFF_PERIOD = 8'h0C;
  localparam logic [7:0] QPV_OFF_VELRUN = 8'h10;
  localparam logic [7:0] QPV_OFF_VELLAST = 8'h14;
  localparam logic [7:0] QPV_OFF_STAT = 8'h18;
  localparam logic [7:0] QPV_OFF_INTSTAT = 8'h1C;
  localparam logic [7:0] QPV_OFF_INTMASK = 8'h20;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int QPV_CTRL_ENABLE = 0;
  localparam int QPV_CTRL_VEL_EN = 1;
  localparam int QPV_CTRL_BOTH = 2;
  localparam int QPV_CTRL_IDXRST = 3;
  localparam int QPV_CTRL_STEPDIR = 4;
  localparam int QPV_CTRL_SWAP = 5;
  localparam int QPV_CTRL_W = 6;

  // ----------------------------------------------------------------
  // Event bit positions
  // ----------------------------------------------------------------
  localparam int QPV_EV_INDEX = 0;
  localparam int QPV_EV_TIMER = 1;
  localparam int QPV_EV_DIR = 2;
  localparam int QPV_EV_ERROR = 3;
  localparam int QPV_EV_W = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [QPV_CTRL_W-1:0] QPV_CTRL_RST = 6'h00;
  localparam logic [31:0] QPV_MAXPOS_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] QPV_PERIOD_RST = 32'h0000_00FF;
  localparam logic [QPV_EV_W-1:0] QPV_EV_RST = 4'h0;

  // Synchronised encoder inputs
  typedef struct packed {
    logic idx;
    logic chb;
    logic cha;
  } qpv_pins_s;

endpackage : qpv_pkg

// >>> src/qpv_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; a change is taken once stages two and three agree
module qpv_sync
  import qpv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);

  logic [2:0] s1_q; // First stage, read only by s2
  logic [2:0] s2_q;
  logic [2:0] s3_q;

  // Shift chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered output per bit
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_out[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          sync_out[g] <= s3_q[g];
        end
      end
    end
  endgenerate

endmodule // qpv_sync
`default_nettype wire

// >>> bench/qpv_decoder_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Bus and interrupt checks
// ----
module qpv_decoder_properties
  import qpv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, rd, wr;
  logic [5:0] ctrl_q;
  logic [3:0] mask_q;
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign wr = acc && pwrite;
  // Shadow of the fields software wrote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= QPV_CTRL_RST;
      mask_q <= QPV_EV_RST;
    end else begin
      if (wr && paddr == QPV_OFF_CTRL) ctrl_q <= pwdata[5:0];
      if (wr && paddr == QPV_OFF_INTMASK) mask_q <= pwdata[3:0];
    end
  end
  a_ready_no_wait: assert property (acc |-> pready)
    else $error("pready low in access");
  a_unmapped_refused: assert property (acc && paddr > QPV_OFF_INTMASK
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
  a_mapped_accepted: assert property (acc && paddr <= QPV_OFF_INTMASK && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped refused");
  a_ctrl_read_back: assert property (rd && paddr == QPV_OFF_CTRL |-> prdata[5:0] == ctrl_q)
    else $error("control readback wrong");
  a_mask_read_back: assert property (rd && paddr == QPV_OFF_INTMASK |-> prdata[3:0] == mask_q)
    else $error("mask readback wrong");
  a_irq_all_masked: assert property (mask_q == 4'h0 |-> !irq)
    else $error("irq with all masked");
  a_irq_from_status: assert property (rd && paddr == QPV_OFF_INTSTAT
    |-> irq == |(prdata[3:0] & mask_q)) else $error("irq differs from status");
  a_mask_off_drops: assert property (wr && paddr == QPV_OFF_INTMASK && pwdata[3:0] == 4'h0
    |=> !irq) else $error("irq after masking");
  cover property ($rose(irq));
  cover property (acc && pslverr);
  cover property (wr && paddr == QPV_OFF_INTSTAT && irq);
endmodule // qpv_decoder_properties
bind qpv_decoder qpv_decoder_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// >>> bench/qpv_encoder_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Rotary encoder with index output
// ----
module qpv_encoder_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic rev,
  input wire logic sd,
  input wire logic glitch,
  input wire logic idx,
  output logic enc_a,
  output logic enc_b,
  output logic enc_index
);
  logic [1:0] ph_q;
  logic sda_q;
  // Phase walks one quarter per step; a glitch moves both lines at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 2'h0;
      sda_q <= 1'b0;
    end else begin
      if (glitch) ph_q <= ph_q + 2'h2;
      else if (step && !sd) ph_q <= rev ? ph_q - 2'h1 : ph_q + 2'h1;
      if (step && sd) sda_q <= !sda_q;
    end
  end
  // Quadrature pair, or step clock plus direction level
  assign enc_a = sd ? sda_q : ph_q[0] ^ ph_q[1];
  assign enc_b = sd ? rev : ph_q[1];
  assign enc_index = idx;
endmodule // qpv_encoder_model
`default_nettype wire

// >>> bench/qpv_decoder_test.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Self-checking bench
// ----
module qpv_decoder_test
  import qpv_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, irq, serr;
  logic enc_a, enc_b, enc_index, stp, rev, sd, glitch, idx;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, pos;
  int miscompares, num_checks, cycles, seed, n, n2;
  localparam logic [5:0] MODE_CTRL [4] = '{6'h01, 6'h05, 6'h25, 6'h11};
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  always #2 pclk = !pclk;
  qpv_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index), .irq(irq));
  qpv_encoder_model enc (.pclk(pclk), .presetn(presetn), .step(stp), .rev(rev), .sd(sd),
    .glitch(glitch), .idx(idx), .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index));
  // Position change for a move of k quarter steps
  function automatic logic [31:0] delta(input int m, input int k, input logic r);
    int d;
    d = (m == 0 || m == 3) ? k / 2 : k;
    if (r ^ (m == 2)) d = -d;
    return 32'(d);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the ready edge; only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask
  // Steps spaced eight cycles apart
  task automatic mv(input int k, input logic r);
    rev <= r;
    repeat (8) @(posedge pclk);
    repeat (k) begin
      stp <= 1'b1;
      @(posedge pclk);
      stp <= 1'b0;
      repeat (7) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask
  task automatic idxp();
    idx <= 1'b1;
    repeat (6) @(posedge pclk);
    idx <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    {psel, penable, pwrite, stp, rev, sd, glitch, idx} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'hb0e6;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(QPV_OFF_CTRL, ALL, 32'h0);
    rd(QPV_OFF_MAXPOS, ALL, QPV_MAXPOS_RST);
    rd(QPV_OFF_PERIOD, ALL, QPV_PERIOD_RST);
    rd(8'h24, ALL, 32'h0);
    chk(32'(serr), 32'h1);
    wr(QPV_OFF_INTMASK, 32'hF);
    // Every input mode, random move lengths
    for (int m = 0; m < 4; m++) begin
      sd <= (m == 3);
      wr(QPV_OFF_CTRL, 32'(MODE_CTRL[m]));
      repeat (10) @(posedge pclk);
      wr(QPV_OFF_POS, 32'h0);
      wr(QPV_OFF_INTSTAT, 32'hF);
      n = 2 * (1 + ($random(seed) & 7));
      n2 = 2 * (1 + ($random(seed) & 7));
      mv(n, 1'b0);
      pos = delta(m, n, 1'b0);
      rd(QPV_OFF_POS, ALL, pos);
      mv(n2, 1'b1);
      pos = pos + delta(m, n2, 1'b1);
      rd(QPV_OFF_POS, ALL, pos);
      rd(QPV_OFF_STAT, 32'h1, 32'(m != 2));
      rd(QPV_OFF_INTSTAT, 32'h4, 32'h4);
    end
    wr(QPV_OFF_INTSTAT, 32'hF);
    wr(QPV_OFF_INTMASK, 32'h4);
    mv(2, 1'b0);
    chk(32'(irq), 32'h1);
    wr(QPV_OFF_INTMASK, 32'h0);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    wr(QPV_OFF_INTMASK, 32'hF);
    wr(QPV_OFF_INTSTAT, 32'hF);
    rd(QPV_OFF_INTSTAT, ALL, 32'h0);
    chk(32'(irq), 32'h0);
    // Both lines moving together
    sd <= 1'b0;
    wr(QPV_OFF_CTRL, 32'h5);
    repeat (10) @(posedge pclk);
    wr(QPV_OFF_INTSTAT, 32'hF);
    glitch <= 1'b1;
    @(posedge pclk);
    glitch <= 1'b0;
    repeat (10) @(posedge pclk);
    rd(QPV_OFF_INTSTAT, 32'h8, 32'h8);
    rd(QPV_OFF_STAT, 32'h2, 32'h2);
    wr(QPV_OFF_INTSTAT, 32'h8);
    rd(QPV_OFF_STAT, 32'h2, 32'h0);
    // Index reload in both directions
    wr(QPV_OFF_MAXPOS, 32'h63);
    wr(QPV_OFF_CTRL, 32'hD);
    wr(QPV_OFF_POS, 32'h0);
    mv(4, 1'b0);
    idxp();
    rd(QPV_OFF_POS, ALL, 32'h0);
    mv(4, 1'b1);
    idxp();
    rd(QPV_OFF_POS, ALL, 32'h63);
    rd(QPV_OFF_INTSTAT, 32'h1, 32'h1);
    // Without index reset the count is left alone
    wr(QPV_OFF_CTRL, 32'h5);
    idxp();
    rd(QPV_OFF_POS, ALL, 32'h63);
    // Velocity over 100-cycle periods
    wr(QPV_OFF_PERIOD, 32'h63);
    wr(QPV_OFF_CTRL, 32'h6);
    mv(10, 1'b0);
    rd(QPV_OFF_VELRUN, ALL, 32'h0);
    wr(QPV_OFF_CTRL, 32'h7);
    fork
      mv(40, 1'b0);
      begin
        repeat (250) @(posedge pclk);
        apb(1'b0, QPV_OFF_VELLAST, 32'h0);
        chk(32'(rdat == 32'hC || rdat == 32'hD), 32'h1);
        apb(1'b0, QPV_OFF_VELRUN, 32'h0);
        chk(32'(rdat >= 32'h4 && rdat <= 32'h9), 32'h1);
      end
    join
    wr(QPV_OFF_INTSTAT, 32'hF);
    repeat (250) @(posedge pclk);
    rd(QPV_OFF_VELLAST, ALL, 32'h0);
    rd(QPV_OFF_INTSTAT, 32'h2, 32'h2);
    final_report();
  end
endmodule // qpv_decoder_test
`default_nettype wire
